// ==== core/cpc_defs.svh ====
`ifndef CPC_DEFS_SVH
`define CPC_DEFS_SVH

// Register addresses
`define CPC_ADDR_PUMP        6'h09
`define CPC_ADDR_CAL         6'h0a
`define CPC_ADDR_VCO         6'h05

// Reset values
`define CPC_PUMP_RESET       24'h403264
`define CPC_CAL_RESET        24'h002205

// Pump register fields
`define CPC_DN_GAIN_LSB      0
`define CPC_UP_GAIN_LSB      7
`define CPC_OFS_MAG_LSB      14
`define CPC_OFS_UP_BIT       21
`define CPC_OFS_DN_BIT       22
`define CPC_HI_CUR_BIT       23

// Calibration register fields
`define CPC_WIN_LSB          0
`define CPC_CURVE_LSB        3
`define CPC_WAIT_LSB         6
`define CPC_SAR_LSB          8
`define CPC_FORCE_CURVE_BIT  10
`define CPC_BYPASS_TUNE_BIT  11
`define CPC_NO_TRIG_BIT      12
`define CPC_CLK_SEL_LSB      13
`define CPC_FALL_EDGE_BIT    15
`define CPC_RDIV_BYP_BIT     16

// Current steps in microamps
`define CPC_GAIN_STEP_UA     20
`define CPC_OFS_STEP_UA      5

// Calibration timing
`define CPC_WAIT_PERIODS     7'h64
`define CPC_SAR_MAX_BITS     4'h8
`define CPC_FSM_CLK_MAX_MHZ  50

// Serial frame: chip id(3), read flag(1), address(6), data(24)
`define CPC_FRAME_BITS       6'h22
`define CPC_HDR_LAST         6'h09
`define CPC_CHIP_LAST        6'h02
`define CPC_RD_SHIFT_FIRST   6'h0b

`endif

// ==== core/cpc_pkg.sv ====
package cpc_pkg;

  typedef logic [23:0] cpc_word_t;

  typedef enum logic [1:0] {
    CPC_IDLE  = 2'b00,
    CPC_SHIFT = 2'b01,
    CPC_DONE  = 2'b10
  } cpc_state_e;

endpackage

// ==== core/cpc_sync.sv ====
`timescale 1ns/1ps

module cpc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic CLK,
  input  wire logic RESETN,
  input  wire logic d,
  output logic      q
);

  logic meta_r;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// ==== core/cpc_config_regs.sv ====
`timescale 1ns/1ps
`include "cpc_defs.svh"

module cpc_config_regs
  import cpc_pkg::*;
#(
  parameter logic [2:0] CHIP_ID = 3'h0  // Arbitrary value
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        SEN_N,
  input  wire logic        SCK,
  input  wire logic        SDI,
  output logic             SDO,
  output logic             SDO_OEN,
  input  wire logic        PAD_EN,
  input  wire logic        PAD_ALWAYS_ON,
  output logic [6:0]       PUMP_DOWN_GAIN,
  output logic [6:0]       PUMP_UP_GAIN,
  output logic [6:0]       OFFSET_MAG,
  output logic             UPWARD_OFFSET_ENABLE,
  output logic             DOWNWARD_OFFSET_ENABLE,
  output logic             HIGH_CURRENT_PUMP,
  output logic [11:0]      DOWN_CURRENT_UA,
  output logic [11:0]      UP_CURRENT_UA,
  output logic [9:0]       OFFSET_CURRENT_UA,
  output logic [8:0]       WINDOW_CYCLES,
  output logic             CURVE_ADJ_ENABLE,
  output logic signed [2:0] CURVE_ADJ,
  output logic [6:0]       WAIT_PERIODS,
  output logic [1:0]       WAIT_AFTER_MEAS,
  output logic [3:0]       SAR_BITS,
  output logic             FORCE_CURVE,
  output logic             BYPASS_VCO_TUNING,
  output logic             SUPPRESS_VCO_WRITE_TRANSFER,
  output logic [5:0]       CAL_CLK_DIVIDE,
  output logic             CAL_CLK_FALLING_EDGE,
  output logic             FORCE_RDIV_BYPASS,
  output logic             VCO_XFER_START,
  output logic [23:0]      VCO_XFER_DATA
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sen_n_s;
  logic sck_s;
  logic sdi_s;

  cpc_sync #(
    .RST_VAL (1'b1)
  ) u_sync_sen (
    .CLK     (CLK),
    .RESETN  (RESETN),
    .d       (SEN_N),
    .q       (sen_n_s)
  );

  cpc_sync #(.RST_VAL(1'b0)) u_sync_sck (
    .CLK     (CLK),
    .RESETN  (RESETN),
    .d       (SCK),
    .q       (sck_s)
  );

  cpc_sync #(.RST_VAL(1'b0)) u_sync_sdi (
    .CLK     (CLK),
    .RESETN  (RESETN),
    .d       (SDI),
    .q       (sdi_s)
  );

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic sck_d_r;
  logic sck_rise;
  logic sck_fall;
  logic selected;

  // Select sync resets high so the frame logic starts deselected
  assign selected = ~sen_n_s;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
    end
  end

  assign sck_rise = selected & sck_s & ~sck_d_r;
  assign sck_fall = selected & ~sck_s & sck_d_r;

  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  cpc_state_e  state_r;
  cpc_state_e  state_nxt;
  logic [5:0]  cnt_r;
  logic [32:0] sr_r;
  logic [33:0] sr_nxt;
  logic        last_bit;
  logic        frame_write;

  assign sr_nxt      = {sr_r, sdi_s};
  assign last_bit    = sck_rise & (cnt_r == `CPC_FRAME_BITS - 6'h01);
  assign frame_write = last_bit & ~sr_nxt[30] & (sr_nxt[33:31] == CHIP_ID);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CPC_IDLE: begin
        if (selected) begin
          state_nxt = CPC_SHIFT;
        end
      end
      CPC_SHIFT: begin
        if (!selected) begin
          state_nxt = CPC_IDLE;
        end else if (last_bit) begin
          state_nxt = CPC_DONE;
        end
      end
      CPC_DONE: begin
        if (!selected) begin
          state_nxt = CPC_IDLE;
        end
      end
      default: begin
        state_nxt = CPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= CPC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_r <= 6'h00;
      sr_r  <= 33'h0;
    end else if (state_r != CPC_SHIFT) begin
      cnt_r <= 6'h00;
      sr_r  <= 33'h0;
    end else if (sck_rise) begin
      cnt_r <= cnt_r + 6'h01;
      sr_r  <= sr_nxt[32:0];
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  cpc_word_t pump_r;
  cpc_word_t cal_r;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pump_r <= `CPC_PUMP_RESET;
    end else if (frame_write && sr_nxt[29:24] == `CPC_ADDR_PUMP) begin
      pump_r <= sr_nxt[23:0];
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cal_r <= `CPC_CAL_RESET;
    end else if (frame_write && sr_nxt[29:24] == `CPC_ADDR_CAL) begin
      cal_r <= sr_nxt[23:0];
    end
  end

  // ----------------------------------------------------------------
  // VCO register write trigger
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      VCO_XFER_START <= 1'b0;
      VCO_XFER_DATA  <= 24'h000000;
    end else begin
      VCO_XFER_START <= frame_write && sr_nxt[29:24] == `CPC_ADDR_VCO &&
                        !cal_r[`CPC_NO_TRIG_BIT];
      if (frame_write && sr_nxt[29:24] == `CPC_ADDR_VCO) begin
        VCO_XFER_DATA <= sr_nxt[23:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read back and data pin
  // ----------------------------------------------------------------
  logic [23:0] rd_r;
  logic        rd_r_act;
  logic        foreign_r;
  logic [5:0]  rd_addr;

  assign rd_addr = sr_nxt[5:0];

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_r     <= 24'h000000;
      rd_r_act <= 1'b0;
    end else if (state_r != CPC_SHIFT) begin
      rd_r_act <= 1'b0;
    end else if (sck_rise && cnt_r == `CPC_HDR_LAST) begin
      rd_r_act <= sr_nxt[6] && sr_nxt[9:7] == CHIP_ID;
      if (rd_addr == `CPC_ADDR_PUMP) begin
        rd_r <= pump_r;
      end else if (rd_addr == `CPC_ADDR_CAL) begin
        rd_r <= cal_r;
      end else begin
        rd_r <= 24'h000000;
      end
    end else if (sck_fall && cnt_r >= `CPC_RD_SHIFT_FIRST) begin
      rd_r <= {rd_r[22:0], 1'b0};
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      foreign_r <= 1'b0;
    end else if (sck_rise && cnt_r == `CPC_CHIP_LAST) begin
      foreign_r <= sr_nxt[2:0] != CHIP_ID;
    end else if (sck_rise && cnt_r == 6'h00) begin
      foreign_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      SDO     <= 1'b0;
      SDO_OEN <= 1'b1;
    end else begin
      SDO <= rd_r_act & rd_r[23];
      if (!PAD_EN) begin
        SDO_OEN <= 1'b1;
      end else if (PAD_ALWAYS_ON) begin
        SDO_OEN <= 1'b0;
      end else begin
        SDO_OEN <= foreign_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Charge pump field decode
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PUMP_DOWN_GAIN         <= 7'h00;
      PUMP_UP_GAIN           <= 7'h00;
      OFFSET_MAG             <= 7'h00;
      UPWARD_OFFSET_ENABLE   <= 1'b0;
      DOWNWARD_OFFSET_ENABLE <= 1'b0;
      HIGH_CURRENT_PUMP      <= 1'b0;
      DOWN_CURRENT_UA        <= 12'h000;
      UP_CURRENT_UA          <= 12'h000;
      OFFSET_CURRENT_UA      <= 10'h000;
    end else begin
      PUMP_DOWN_GAIN         <= pump_r[`CPC_DN_GAIN_LSB +: 7];
      PUMP_UP_GAIN           <= pump_r[`CPC_UP_GAIN_LSB +: 7];
      OFFSET_MAG             <= pump_r[`CPC_OFS_MAG_LSB +: 7];
      UPWARD_OFFSET_ENABLE   <= pump_r[`CPC_OFS_UP_BIT];
      DOWNWARD_OFFSET_ENABLE <= pump_r[`CPC_OFS_DN_BIT];
      HIGH_CURRENT_PUMP      <= pump_r[`CPC_HI_CUR_BIT];
      DOWN_CURRENT_UA        <= 12'({5'h00, pump_r[`CPC_DN_GAIN_LSB +: 7]} *
                                    `CPC_GAIN_STEP_UA);
      UP_CURRENT_UA          <= 12'({5'h00, pump_r[`CPC_UP_GAIN_LSB +: 7]} *
                                    `CPC_GAIN_STEP_UA);
      OFFSET_CURRENT_UA      <= 10'({3'h0, pump_r[`CPC_OFS_MAG_LSB +: 7]} *
                                    `CPC_OFS_STEP_UA);
    end
  end

  // ----------------------------------------------------------------
  // Calibration field decode
  // ----------------------------------------------------------------
  logic [1:0] clk_sel;

  assign clk_sel = cal_r[`CPC_CLK_SEL_LSB +: 2];

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      WINDOW_CYCLES               <= 9'h000;
      CURVE_ADJ_ENABLE            <= 1'b0;
      CURVE_ADJ                   <= 3'sh0;
      WAIT_PERIODS                <= 7'h00;
      WAIT_AFTER_MEAS             <= 2'h0;
      SAR_BITS                    <= 4'h0;
      FORCE_CURVE                 <= 1'b0;
      BYPASS_VCO_TUNING           <= 1'b0;
      SUPPRESS_VCO_WRITE_TRANSFER <= 1'b0;
      CAL_CLK_DIVIDE              <= 6'h00;
      CAL_CLK_FALLING_EDGE        <= 1'b0;
      FORCE_RDIV_BYPASS           <= 1'b0;
    end else begin
      WINDOW_CYCLES    <= 9'h001 << cal_r[`CPC_WIN_LSB +: 3];
      CURVE_ADJ_ENABLE <= cal_r[`CPC_CURVE_LSB +: 3] != 3'h0;
      CURVE_ADJ        <= $signed(cal_r[`CPC_CURVE_LSB +: 3]);
      WAIT_PERIODS     <= `CPC_WAIT_PERIODS;
      WAIT_AFTER_MEAS  <= cal_r[`CPC_WAIT_LSB +: 2];
      SAR_BITS         <= `CPC_SAR_MAX_BITS -
                          {2'h0, cal_r[`CPC_SAR_LSB +: 2]};
      FORCE_CURVE      <= cal_r[`CPC_FORCE_CURVE_BIT];
      BYPASS_VCO_TUNING <= cal_r[`CPC_BYPASS_TUNE_BIT];
      SUPPRESS_VCO_WRITE_TRANSFER <= cal_r[`CPC_NO_TRIG_BIT];
      unique case (clk_sel)
        2'h0: CAL_CLK_DIVIDE <= 6'h01;
        2'h1: CAL_CLK_DIVIDE <= 6'h04;
        2'h2: CAL_CLK_DIVIDE <= 6'h10;
        2'h3: CAL_CLK_DIVIDE <= 6'h20;
      endcase
      CAL_CLK_FALLING_EDGE <= cal_r[`CPC_FALL_EDGE_BIT];
      FORCE_RDIV_BYPASS    <= cal_r[`CPC_RDIV_BYP_BIT];
    end
  end

endmodule

// ==== verif/cpc_config_regs_monitor.sv ====
`timescale 1ns/1ps
module cpc_monitor (
  input wire logic              CLK,
  input wire logic              RESETN,
  input wire logic              PAD_EN,
  input wire logic              PAD_ALWAYS_ON,
  input wire logic              SDO_OEN,
  input wire logic [6:0]        PUMP_DOWN_GAIN,
  input wire logic [6:0]        PUMP_UP_GAIN,
  input wire logic [6:0]        OFFSET_MAG,
  input wire logic [11:0]       DOWN_CURRENT_UA,
  input wire logic [11:0]       UP_CURRENT_UA,
  input wire logic [9:0]        OFFSET_CURRENT_UA,
  input wire logic [8:0]        WINDOW_CYCLES,
  input wire logic              CURVE_ADJ_ENABLE,
  input wire logic signed [2:0] CURVE_ADJ,
  input wire logic [6:0]        WAIT_PERIODS,
  input wire logic [3:0]        SAR_BITS,
  input wire logic [5:0]        CAL_CLK_DIVIDE,
  input wire logic              SUPPRESS_VCO_WRITE_TRANSFER,
  input wire logic              VCO_XFER_START,
  input wire logic              HIGH_CURRENT_PUMP
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // ----------
  // Assertions
  // ----------
  property p_dn_cur;
    $stable(PUMP_DOWN_GAIN) |-> DOWN_CURRENT_UA == 12'(PUMP_DOWN_GAIN) * 12'h014;
  endproperty
  a_dn_cur: assert property (p_dn_cur) else $error("down current wrong");
  property p_up_cur;
    $stable(PUMP_UP_GAIN) |-> UP_CURRENT_UA == 12'(PUMP_UP_GAIN) * 12'h014;
  endproperty
  a_up_cur: assert property (p_up_cur) else $error("up current wrong");
  property p_ofs_cur;
    $stable(OFFSET_MAG) |-> OFFSET_CURRENT_UA == 10'(OFFSET_MAG) * 10'h005;
  endproperty
  a_ofs_cur: assert property (p_ofs_cur) else $error("offset current wrong");
  property p_window;
    $past(RESETN) |-> $onehot(WINDOW_CYCLES);
  endproperty
  a_window: assert property (p_window) else $error("window not a power of two");
  property p_curve;
    CURVE_ADJ_ENABLE == (CURVE_ADJ != 3'sh0);
  endproperty
  a_curve: assert property (p_curve) else $error("curve enable wrong");
  property p_wait;
    $past(RESETN) |-> WAIT_PERIODS == 7'h64;
  endproperty
  a_wait: assert property (p_wait) else $error("wait periods wrong");
  property p_sar;
    $past(RESETN) |-> SAR_BITS inside {4'h5, 4'h6, 4'h7, 4'h8};
  endproperty
  a_sar: assert property (p_sar) else $error("sar depth out of range");
  property p_div;
    $past(RESETN) |-> CAL_CLK_DIVIDE inside {6'h01, 6'h04, 6'h10, 6'h20};
  endproperty
  a_div: assert property (p_div) else $error("clock divide illegal");
  property p_xfer;
    VCO_XFER_START |-> !SUPPRESS_VCO_WRITE_TRANSFER ##1 !VCO_XFER_START;
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer pulse wrong");
  property p_pad_off;
    !PAD_EN [*3] |-> SDO_OEN;
  endproperty
  a_pad_off: assert property (p_pad_off) else $error("data pin driven while off");
  property p_pad_on;
    (PAD_EN && PAD_ALWAYS_ON) [*3] |-> !SDO_OEN;
  endproperty
  a_pad_on: assert property (p_pad_on) else $error("data pin released");
  c_xfer: cover property (VCO_XFER_START);
  c_hi: cover property ($rose(HIGH_CURRENT_PUMP));
  c_rel: cover property ($rose(SDO_OEN) && PAD_EN);
endmodule

bind cpc_config_regs cpc_monitor cpc_monitor_inst (
  .CLK, .RESETN, .PAD_EN, .PAD_ALWAYS_ON, .SDO_OEN, .PUMP_DOWN_GAIN, .PUMP_UP_GAIN,
  .OFFSET_MAG, .DOWN_CURRENT_UA, .UP_CURRENT_UA, .OFFSET_CURRENT_UA, .WINDOW_CYCLES,
  .CURVE_ADJ_ENABLE, .CURVE_ADJ, .WAIT_PERIODS, .SAR_BITS, .CAL_CLK_DIVIDE,
  .SUPPRESS_VCO_WRITE_TRANSFER, .VCO_XFER_START, .HIGH_CURRENT_PUMP
);

// ==== verif/tb_charge_pump_vco_auto_calibration_config.sv ====
`timescale 1ns/1ps
module tb_charge_pump_vco_auto_calibration_config
  import cpc_pkg::*;
();
  localparam logic [2:0] OWN_ID = 3'h3;  // Arbitrary value
  logic CLK = 1'b0, RESETN = 1'b0, SEN_N = 1'b1, SCK = 1'b0, SDI = 1'b0;
  logic PAD_EN = 1'b1, PAD_ALWAYS_ON = 1'b0;
  logic SDO, SDO_OEN, UPWARD_OFFSET_ENABLE, DOWNWARD_OFFSET_ENABLE, HIGH_CURRENT_PUMP;
  logic CURVE_ADJ_ENABLE, FORCE_CURVE, BYPASS_VCO_TUNING, SUPPRESS_VCO_WRITE_TRANSFER;
  logic CAL_CLK_FALLING_EDGE, FORCE_RDIV_BYPASS, VCO_XFER_START;
  logic [6:0] PUMP_DOWN_GAIN, PUMP_UP_GAIN, OFFSET_MAG, WAIT_PERIODS;
  logic [11:0] DOWN_CURRENT_UA, UP_CURRENT_UA;
  logic [9:0] OFFSET_CURRENT_UA;
  logic [8:0] WINDOW_CYCLES;
  logic signed [2:0] CURVE_ADJ;
  logic [1:0] WAIT_AFTER_MEAS;
  logic [3:0] SAR_BITS;
  logic [5:0] CAL_CLK_DIVIDE;
  logic [23:0] VCO_XFER_DATA;
  int miscompares = 0, samples_checked = 0, pulses = 0, cycles = 0;
  integer seed = 32'hceee;
  wire logic [94:0] seen = {PUMP_DOWN_GAIN, PUMP_UP_GAIN, OFFSET_MAG, UPWARD_OFFSET_ENABLE,
    DOWNWARD_OFFSET_ENABLE, HIGH_CURRENT_PUMP, DOWN_CURRENT_UA, UP_CURRENT_UA,
    OFFSET_CURRENT_UA, WINDOW_CYCLES, CURVE_ADJ_ENABLE, CURVE_ADJ, WAIT_PERIODS,
    WAIT_AFTER_MEAS, SAR_BITS, FORCE_CURVE, BYPASS_VCO_TUNING, SUPPRESS_VCO_WRITE_TRANSFER,
    CAL_CLK_DIVIDE, CAL_CLK_FALLING_EDGE, FORCE_RDIV_BYPASS};

  cpc_config_regs #(.CHIP_ID(OWN_ID)) cpc_config_regs_inst (
    .CLK, .RESETN, .SEN_N, .SCK, .SDI, .SDO, .SDO_OEN, .PAD_EN, .PAD_ALWAYS_ON,
    .PUMP_DOWN_GAIN, .PUMP_UP_GAIN, .OFFSET_MAG, .UPWARD_OFFSET_ENABLE,
    .DOWNWARD_OFFSET_ENABLE, .HIGH_CURRENT_PUMP, .DOWN_CURRENT_UA, .UP_CURRENT_UA,
    .OFFSET_CURRENT_UA, .WINDOW_CYCLES, .CURVE_ADJ_ENABLE, .CURVE_ADJ, .WAIT_PERIODS,
    .WAIT_AFTER_MEAS, .SAR_BITS, .FORCE_CURVE, .BYPASS_VCO_TUNING,
    .SUPPRESS_VCO_WRITE_TRANSFER, .CAL_CLK_DIVIDE, .CAL_CLK_FALLING_EDGE,
    .FORCE_RDIV_BYPASS, .VCO_XFER_START, .VCO_XFER_DATA
  );

  always #2.5 CLK = ~CLK;
  always @(negedge CLK) begin
    if (VCO_XFER_START === 1'b1) pulses <= pulses + 1;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      close_out();
    end
  end
  // --------------
  // Bench helpers
  // --------------
  function automatic logic [94:0] exp_dec(input cpc_word_t p, input cpc_word_t c);
    logic [3:0][5:0] dv;
    dv = {6'h20, 6'h10, 6'h04, 6'h01};
    return {p[6:0], p[13:7], p[20:14], p[21], p[22], p[23], 12'(p[6:0] * 12'h014),
      12'(p[13:7] * 12'h014), 10'(p[20:14] * 10'h005), 9'(9'h001 << c[2:0]),
      c[5:3] != 3'h0, c[5:3], 7'h64, c[7:6], 4'h8 - 4'(c[9:8]), c[10], c[11], c[12],
      dv[c[14:13]], c[15], c[16]};
  endfunction
  task automatic check(input logic [94:0] got, input logic [94:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [2:0] id, input logic rd, input logic [5:0] adr,
                       input cpc_word_t d, output cpc_word_t q);
    logic [33:0] w;
    w = {id, rd, adr, d};
    q = '0;
    @(posedge CLK) SEN_N <= 1'b0;
    for (int i = 33; i >= 0; i--) begin
      @(posedge CLK) SDI <= w[i];
      repeat (6) @(posedge CLK);
      @(negedge CLK) if (i < 24) q = {q[22:0], SDO};
      @(posedge CLK) SCK <= 1'b1;
      repeat (6) @(posedge CLK);
      SCK <= 1'b0;
    end
    repeat (6) @(posedge CLK);
    SEN_N <= 1'b1;
    repeat (8) @(posedge CLK);
    @(negedge CLK);
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // --------------
  // Main sequence
  // --------------
  initial begin
    cpc_word_t pw, cw, q, d;
    int v0;
    pw = 24'h403264;
    cw = 24'h002205;
    repeat (3) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (4) @(posedge CLK);
    @(negedge CLK);
    check(seen, exp_dec(pw, cw));
    for (int n = 0; n < 17; n++) begin
      frame(OWN_ID, 1'b1, 6'h09, 24'h0, q);
      check(95'(q), 95'(pw));
      frame(OWN_ID, 1'b1, 6'h0a, 24'h0, q);
      check(95'(q), 95'(cw));
      pw = (n == 0) ? 24'hffffff : (n == 1) ? 24'h000000 : 24'($random(seed));
      frame(OWN_ID, 1'b0, 6'h09, pw, q);
      check(seen, exp_dec(pw, cw));
      cw = 24'($random(seed));
      cw[2:0] = ~n[2:0];
      cw[5:3] = n[2:0];
      cw[9:6] = n[3:0];
      cw[14:13] = n[1:0];
      frame(OWN_ID, 1'b0, 6'h0a, cw, q);
      check(seen, exp_dec(pw, cw));
    end
    d = 24'($random(seed));
    cw = cw & 24'hffefff;
    frame(OWN_ID, 1'b0, 6'h0a, cw, q);
    v0 = pulses;
    frame(OWN_ID, 1'b0, 6'h05, d, q);
    check(95'(pulses - v0), 95'(1));
    check(95'(VCO_XFER_DATA), 95'(d));
    cw = cw | 24'h001000;
    frame(OWN_ID, 1'b0, 6'h0a, cw, q);
    v0 = pulses;
    frame(OWN_ID, 1'b0, 6'h05, ~d, q);
    check(95'(pulses - v0), 95'(0));
    check(seen, exp_dec(pw, cw));
    check(95'(SDO_OEN), 95'(0));
    frame(3'h6, 1'b0, 6'h09, ~pw, q);
    check(seen, exp_dec(pw, cw));
    check(95'(SDO_OEN), 95'(1));
    @(posedge CLK);
    PAD_ALWAYS_ON <= 1'b1;
    repeat (4) @(negedge CLK);
    check(95'(SDO_OEN), 95'(0));
    @(posedge CLK);
    PAD_ALWAYS_ON <= 1'b0;
    PAD_EN <= 1'b0;
    repeat (4) @(negedge CLK);
    check(95'(SDO_OEN), 95'(1));
    @(posedge CLK);
    PAD_EN <= 1'b1;
    frame(OWN_ID, 1'b0, 6'h11, ~pw, q);
    frame(OWN_ID, 1'b1, 6'h11, 24'h0, q);
    check(95'(q), 95'(0));
    check(seen, exp_dec(pw, cw));
    close_out();
  end
endmodule
